/* sdad_map.svh */
/*
 * register offsets, field positions, reset values and command coding
 * for the season data access decoder.
 * assumes nothing of its surroundings; definitions only.
 */
`ifndef SDAD_MAP_SVH
`define SDAD_MAP_SVH

// apb register byte offsets
`define SDAD_OFS_CTRL 12'h000
`define SDAD_OFS_CMD 12'h004
`define SDAD_OFS_STATUS 12'h008
`define SDAD_OFS_COUNT 12'h00c

// control register fields
`define SDAD_CTRL_START 0
`define SDAD_CTRL_ERASE 1

// status register fields
`define SDAD_ST_BUSY 0
`define SDAD_ST_ACK 1
`define SDAD_ST_ERR 2

// command word: code in the upper half, data field in the lower half
`define SDAD_CMD_RST 32'h0000_0000
`define SDAD_CAT_SEASON 4'h8

// access scope codes
`define SDAD_SC_SINGLE 4'h0
`define SDAD_SC_SEASON 4'h1
`define SDAD_SC_TARIFF 4'h2
`define SDAD_SC_REG 4'h3
`define SDAD_SC_TYPE 4'h4
`define SDAD_SC_CHAN 4'h5

// last values of each swept field
`define SDAD_SEA_MAX 8'hff
`define SDAD_TAR_MAX 4'hf
`define SDAD_REG_MAX 6'h3f
`define SDAD_TYP_MAX 2'h3
`define SDAD_CH_MAX 3'h7

`endif

/* sdad_pkg.sv */
/*
 * types of the season data access decoder: location, sweep plan and
 * the complete state of the top module.
 * assumes sdad_map.svh is on the include path.
 */
`include "sdad_map.svh"

package sdad_pkg;

	// one season location
	typedef struct packed {
		logic [2:0] ch;
		logic [1:0] typ;
		logic [5:0] rgs;
		logic [3:0] tar;
		logic [7:0] sea;
	} sdad_loc_t;

	// which fields sweep, in order season, tariff, register, type, channel
	typedef struct packed {
		logic ch;
		logic typ;
		logic rgs;
		logic tar;
		logic sea;
	} sdad_free_t;

	typedef enum logic [2:0] {
		SDAD_IDLE = 3'b001,
		SDAD_SCAN = 3'b010,
		SDAD_EMIT = 3'b100
	} sdad_fsm_t;

	// returned record on the output stream
	typedef struct packed {
		logic valid;
		logic long_id;
		logic [31:0] id;
		logic [31:0] value;
	} sdad_rec_t;

	typedef struct packed {
		sdad_fsm_t fsm;
		logic erase;
		logic [3:0] scope;
		sdad_free_t free;
		sdad_loc_t loc;
		logic first;
		logic [15:0] last_code;
		logic [31:0] cmd;
		logic [31:0] prdata;
		logic ack;
		logic err;
		logic [15:0] count;
		sdad_rec_t rec;
	} sdad_st_t;

endpackage

/* sdad_scope.sv */
/*
 * scope decoder: splits a code and data field into a start location and
 * the set of fields to sweep, and flags commands that must be refused.
 * assumes a stable command word from the caller; purely combinational.
 */
`timescale 1ns/1ns
`default_nettype none
`include "sdad_map.svh"

module sdad_scope (
	// command
	input wire logic [31:0] cmd,
	// decoded plan
	output sdad_pkg::sdad_loc_t start,
	output sdad_pkg::sdad_free_t free,
	output logic bad
);

	logic [15:0] code;
	logic [15:0] data;
	logic [3:0] scope;

	assign code = cmd[31:16];
	assign data = cmd[15:0];
	assign scope = data[3:0];

	always_comb begin
		free = '0;
		bad = 1'b0;
		unique case (scope)
			`SDAD_SC_SINGLE: free = 5'b00000;
			`SDAD_SC_SEASON: free = 5'b00001;
			`SDAD_SC_TARIFF: free = 5'b00011;
			`SDAD_SC_REG: free = 5'b00111;
			`SDAD_SC_TYPE: free = 5'b01111;
			`SDAD_SC_CHAN: free = 5'b11111;
			default: bad = 1'b1;
		endcase
		// only the season category is handled here
		if (code[15:12] != `SDAD_CAT_SEASON) begin
			bad = 1'b1;
		end
	end

	// swept fields start from zero, fixed ones from the command
	// one process drives the whole start word, never one driver per field
	always_comb begin
		start.ch = free.ch ? 3'h0 : code[10:8];
		start.typ = free.typ ? 2'h0 : code[7:6];
		start.rgs = free.rgs ? 6'h00 : code[5:0];
		start.tar = free.tar ? 4'h0 : data[15:12];
		start.sea = free.sea ? 8'h00 : data[11:4];
	end

endmodule // sdad_scope

`default_nettype wire

/* sdad_store.sv */
/* season store and record sink beside the decoder.
 assumes only channel 0 is ever populated. */
`timescale 1ns/1ns
`default_nettype none
module sdad_store (
	// clock
	input wire logic pclk,
	// store
	input wire sdad_pkg::sdad_loc_t loc,
	input wire logic loc_erase,
	output logic loc_present,
	output logic [31:0] loc_value,
	// sink
	input wire logic slow,
	output logic rec_ready
);
	// index {typ,rgs,tar,sea}; channel 0 only, to keep the map small
	bit pres [0:(1<<20)-1];
	logic [1:0] cnt = 2'h0;
	initial rec_ready = 1'b0;
	task put(logic [1:0] t, logic [5:0] r, logic [3:0] a, logic [7:0] s);
		pres[{t, r, a, s}] = 1'b1;
	endtask
	assign loc_present = loc.ch == 3'h0 && pres[loc[19:0]];
	// absent places show the inverse, never a stale value
	assign loc_value = loc_present ? {9'h0, loc} : ~{9'h0, loc};
	always @(posedge pclk) begin
		if (loc_erase) pres[loc[19:0]] <= 1'b0;
		cnt <= cnt + 2'h1;
		rec_ready <= !slow || cnt == 2'h3;
	end
endmodule // sdad_store
`default_nettype wire

/* sdad_top.sv */
/*
 * season data access decoder: apb slave that takes a season category
 * command, sweeps the addressed season locations of an outside store and
 * either streams the present records out with their ids or erases them.
 * assumes a store on pclk that answers loc_present and loc_value
 * combinationally from loc, and a record sink with a ready handshake.
 */
// The implementer's own choices: the APB slave port and the address map.
// Behaviour
// - read or erase season locations on command
// - low data digit selects access scope
// - scope codes six to fifteen are reserved
// - single scope touches one exact location
// - all seasons scope ignores season number
// - all tariffs sweeps tariffs and seasons
// - all registers sweeps registers, tariffs, seasons
// - all types sweeps whole channel
// - all channels sweeps every location
// - data type sits in code bits 7:6
// - register sits in code bits 5:0
// - data field: tariff, season, scope digits
// - single read id is code plus data
// - multi read: only the first id and ids with a new code carry it
// - each new code heads its block once
// - present records only, season varies fastest
// - erase uses same coding as read
// - erase acknowledged only when fully done
`timescale 1ns/1ns
`default_nettype none
`include "sdad_map.svh"

module sdad_top (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// season store
	output sdad_pkg::sdad_loc_t loc,
	input wire logic loc_present,
	input wire logic [31:0] loc_value,
	output logic loc_erase,
	// record stream
	output logic rec_valid,
	output logic rec_long,
	output logic [31:0] rec_id,
	output logic [31:0] rec_value,
	input wire logic rec_ready
);

	////////////////////////////////////////////////////////////////////////

	sdad_pkg::sdad_st_t s_q;
	sdad_pkg::sdad_st_t s_d;

	sdad_pkg::sdad_loc_t start;
	sdad_pkg::sdad_free_t free;
	logic bad;

	sdad_scope u_scope (
		.cmd(s_q.cmd),
		.start(start),
		.free(free),
		.bad(bad)
	);

	////////////////////////////////////////////////////////////////////////
	// apb decode; the slave never waits

	logic wr;
	logic rd;
	logic hit;
	logic busy;
	logic start_req;

	assign busy = (s_q.fsm != sdad_pkg::SDAD_IDLE);
	assign wr = psel & penable & pwrite;
	assign rd = psel & ~pwrite;
	assign hit = (paddr == `SDAD_OFS_CTRL) | (paddr == `SDAD_OFS_CMD) |
		(paddr == `SDAD_OFS_STATUS) | (paddr == `SDAD_OFS_COUNT);
	// a start while busy is dropped so the running sweep stays consistent
	assign start_req = wr & (paddr == `SDAD_OFS_CTRL) &
		pwdata[`SDAD_CTRL_START] & ~busy;

	assign pready = 1'b1;
	assign pslverr = psel & penable & ~hit;
	assign prdata = s_q.prdata;

	////////////////////////////////////////////////////////////////////////
	// sweep step: carry chain season, tariff, register, type, channel

	sdad_pkg::sdad_loc_t nxt;
	logic c_tar;
	logic c_rgs;
	logic c_typ;
	logic c_ch;
	logic last;

	always_comb begin
		nxt = s_q.loc;
		c_tar = ~s_q.free.sea | (s_q.loc.sea == `SDAD_SEA_MAX);
		c_rgs = c_tar & (~s_q.free.tar | (s_q.loc.tar == `SDAD_TAR_MAX));
		c_typ = c_rgs & (~s_q.free.rgs | (s_q.loc.rgs == `SDAD_REG_MAX));
		c_ch = c_typ & (~s_q.free.typ | (s_q.loc.typ == `SDAD_TYP_MAX));
		last = c_ch & (~s_q.free.ch | (s_q.loc.ch == `SDAD_CH_MAX));
		if (s_q.free.sea) begin
			nxt.sea = s_q.loc.sea + 8'h01;
		end
		if (s_q.free.tar & c_tar) begin
			nxt.tar = s_q.loc.tar + 4'h1;
		end
		if (s_q.free.rgs & c_rgs) begin
			nxt.rgs = s_q.loc.rgs + 6'h01;
		end
		if (s_q.free.typ & c_typ) begin
			nxt.typ = s_q.loc.typ + 2'h1;
		end
		if (s_q.free.ch & c_ch) begin
			nxt.ch = s_q.loc.ch + 3'h1;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// id of the current location

	logic [15:0] cur_code;
	logic [15:0] cur_data;
	logic need_code;

	assign cur_code = {`SDAD_CAT_SEASON, 1'b0, s_q.loc.ch, s_q.loc.typ,
		s_q.loc.rgs};
	assign cur_data = {s_q.loc.tar, s_q.loc.sea, s_q.scope};
	// single reads always long; a block repeats the code only on change
	assign need_code = s_q.first | (cur_code != s_q.last_code) |
		(s_q.free == '0);

	assign loc = s_q.loc;
	assign loc_erase = (s_q.fsm == sdad_pkg::SDAD_SCAN) & s_q.erase &
		loc_present;

	////////////////////////////////////////////////////////////////////////
	// next state

	always_comb begin
		s_d = s_q;
		// register read data, taken in the setup cycle
		if (rd) begin
			unique case (paddr)
				`SDAD_OFS_CTRL: s_d.prdata = {30'h0, s_q.erase, 1'b0};
				`SDAD_OFS_CMD: s_d.prdata = s_q.cmd;
				`SDAD_OFS_STATUS: s_d.prdata = {29'h0, s_q.err, s_q.ack,
					busy};
				`SDAD_OFS_COUNT: s_d.prdata = {16'h0, s_q.count};
				default: s_d.prdata = 32'h0;
			endcase
		end
		if (wr & (paddr == `SDAD_OFS_CMD) & ~busy) begin
			s_d.cmd = pwdata;
		end
		unique case (s_q.fsm)
			sdad_pkg::SDAD_IDLE: begin
				if (start_req) begin
					s_d.erase = pwdata[`SDAD_CTRL_ERASE];
					s_d.ack = 1'b0;
					s_d.err = 1'b0;
					s_d.count = 16'h0;
					s_d.first = 1'b1;
					s_d.scope = s_q.cmd[3:0];
					s_d.free = free;
					s_d.loc = start;
					if (bad) begin
						s_d.err = 1'b1;
					end else begin
						s_d.fsm = sdad_pkg::SDAD_SCAN;
					end
				end
			end
			sdad_pkg::SDAD_SCAN: begin
				if (loc_present & ~s_q.erase) begin
					s_d.rec.valid = 1'b1;
					s_d.rec.long_id = need_code;
					s_d.rec.id = need_code ? {cur_code, cur_data} :
						{16'h0, cur_data};
					s_d.rec.value = loc_value;
					s_d.first = 1'b0;
					s_d.last_code = cur_code;
					s_d.fsm = sdad_pkg::SDAD_EMIT;
				end else begin
					// absent locations are skipped silently
					if (loc_present) begin
						s_d.count = s_q.count + 16'h0001;
					end
					if (last) begin
						s_d.ack = 1'b1;
						s_d.fsm = sdad_pkg::SDAD_IDLE;
					end else begin
						s_d.loc = nxt;
					end
				end
			end
			sdad_pkg::SDAD_EMIT: begin
				if (rec_ready) begin
					s_d.rec.valid = 1'b0;
					s_d.count = s_q.count + 16'h0001;
					if (last) begin
						s_d.ack = 1'b1;
						s_d.fsm = sdad_pkg::SDAD_IDLE;
					end else begin
						s_d.loc = nxt;
						s_d.fsm = sdad_pkg::SDAD_SCAN;
					end
				end
			end
		endcase
	end

	////////////////////////////////////////////////////////////////////////

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_q <= '0;
			s_q.fsm <= sdad_pkg::SDAD_IDLE;
			s_q.cmd <= `SDAD_CMD_RST;
		end else begin
			s_q <= s_d;
		end
	end

	assign rec_valid = s_q.rec.valid;
	assign rec_long = s_q.rec.long_id;
	assign rec_id = s_q.rec.id;
	assign rec_value = s_q.rec.value;

endmodule // sdad_top

`default_nettype wire

/* sdad_top_asserts.sv */
/* port checker for sdad_top.
 assumes a bind onto sdad_top, one clock domain. */
`timescale 1ns/1ns
`default_nettype none
module sdad_top_asserts (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// watched
	input wire logic pready,
	input wire sdad_pkg::sdad_loc_t loc,
	input wire logic loc_present,
	input wire logic loc_erase,
	input wire logic rec_valid,
	input wire logic rec_long,
	input wire logic [31:0] rec_id,
	input wire logic [31:0] rec_value,
	input wire logic rec_ready
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	a_ready_const: assert property (pready)
		else $error("pready low");
	a_erase_present: assert property (loc_erase |-> loc_present && !rec_valid)
		else $error("erase of absent location");
	a_rec_hold: assert property (rec_valid && !rec_ready |=>
		rec_valid && $stable(rec_id) && $stable(rec_value))
		else $error("record changed while stalled");
	a_valid_drop: assert property (rec_valid && rec_ready |=> !rec_valid)
		else $error("record not released");
	a_rise_present: assert property ($rose(rec_valid) |-> $past(loc_present))
		else $error("record of absent location");
	a_short_id: assert property (rec_valid && !rec_long |->
		rec_id[31:16] == 16'h0000) else $error("short id has code");
	a_long_code: assert property (rec_valid && rec_long |->
		rec_id[31:16] == {4'h8, 1'b0, loc.ch, loc.typ, loc.rgs})
		else $error("code part wrong");
	a_data_loc: assert property (rec_valid |->
		rec_id[15:4] == {loc.tar, loc.sea}) else $error("data part wrong");
endmodule // sdad_top_asserts
`default_nettype wire

/* sdad_top_test.sv */
/* self-checking bench for sdad_top.
 assumes sdad_store as store and sink. */
`timescale 1ns/1ns
`default_nettype none
`include "sdad_map.svh"
module sdad_top_test;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
	logic slow = 0, er;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, rd, loc_value, rec_id, rec_value;
	logic [31:0] val = 32'h0;
	logic pready, pslverr, loc_present, loc_erase, rec_valid;
	logic rec_long, rec_ready;
	sdad_pkg::sdad_loc_t loc;
	logic [32:0] got [$];
	int bad_count = 0, n_tests = 0, cyc = 0, i;
	sdad_top dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
		.pwdata, .prdata, .pready, .pslverr, .loc, .loc_present,
		.loc_value, .loc_erase, .rec_valid, .rec_long, .rec_id,
		.rec_value, .rec_ready);
	sdad_store store_u (.pclk, .loc, .loc_erase, .loc_present,
		.loc_value, .slow, .rec_ready);
	initial forever #20 pclk = ~pclk;
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		if (cyc == 40000) begin
			bad_count++;
			results();
		end
	end
	always @(negedge pclk) if (rec_valid === 1'b1 && rec_ready) begin
		got.push_back({rec_long, rec_id});
		val = rec_value;
	end
	task results;
		$display("tests %0d errors %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	task chk(string n, logic [32:0] e, logic [32:0] g);
		n_tests++;
		if (g !== e) begin
			bad_count++;
			$display("CHECK FAILED %s exp %h got %h", n, e, g);
		end
	endtask
	task apb(logic w, logic [11:0] a, logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata; er = pslverr;
		psel <= 1'b0; penable <= 1'b0;
	endtask
	task run(logic [31:0] c, logic e, logic [2:0] st);
		got.delete();
		apb(1'b1, `SDAD_OFS_CMD, c);
		apb(1'b1, `SDAD_OFS_CTRL, {30'h0, e, 1'b1});
		for (i = 0; i < 6000; i++) begin
			apb(1'b0, `SDAD_OFS_STATUS, 32'h0);
			if (rd[0] !== 1'b1) break;
		end
		chk("status", st, rd[2:0]);
	endtask
	task t_single;
		store_u.put(2'h1, 6'h0, 4'h1, 8'h01);
		store_u.put(2'h1, 6'h0, 4'h1, 8'h02);
		run(32'h8040_1010, 1'b0, 3'b010);
		chk("n", 1, got.size());
		chk("id", {1'b1, 32'h8040_1010}, got[0]);
		chk("value", {9'h0, 3'h0, 2'h1, 6'h00, 4'h1, 8'h01}, val);
	endtask
	task t_seasons;
		slow = 1'b1;
		store_u.put(2'h0, 6'h2, 4'h1, 8'h00);
		store_u.put(2'h0, 6'h2, 4'h1, 8'h01);
		store_u.put(2'h0, 6'h2, 4'h1, 8'hff);
		store_u.put(2'h0, 6'h2, 4'h2, 8'h00);
		run(32'h8002_1ab1, 1'b0, 3'b010);
		slow = 1'b0;
		chk("n", 3, got.size());
		chk("id0", {1'b1, 32'h8002_1001}, got[0]);
		chk("id1", {1'b0, 32'h0000_1011}, got[1]);
		chk("id2", {1'b0, 32'h0000_1ff1}, got[2]);
	endtask
	task t_erase;
		store_u.put(2'h0, 6'h5, 4'h0, 8'h03);
		store_u.put(2'h0, 6'h5, 4'hf, 8'hff);
		store_u.put(2'h0, 6'h6, 4'h0, 8'h00);
		run(32'h8005_0002, 1'b1, 3'b010);
		apb(1'b0, `SDAD_OFS_COUNT, 32'h0);
		chk("count", 2, rd);
		apb(1'b0, `SDAD_OFS_CTRL, 32'h0);
		chk("ctrl", 32'h0000_0002, rd);
		apb(1'b0, `SDAD_OFS_CMD, 32'h0);
		chk("cmd", 32'h8005_0002, rd);
		chk("kept", 1, store_u.pres[{2'h0, 6'h6, 4'h0, 8'h00}]);
		chk("n", 0, got.size());
		store_u.put(2'h0, 6'h0, 4'h1, 8'hff);
		run(32'h8000_1ff0, 1'b1, 3'b010);
		run(32'h8000_1ff0, 1'b0, 3'b010);
		chk("gone", 0, got.size());
	endtask
	task t_reserved;
		store_u.put(2'h0, 6'h7, 4'h0, 8'h00);
		for (int s = 6; s < 16; s++) begin
			run({28'h8007_000, s[3:0]}, 1'b1, 3'b100);
			chk("kept", 1, store_u.pres[{2'h0, 6'h7, 4'h0, 8'h00}]);
		end
		apb(1'b0, 12'h010, 32'h0);
		chk("pslverr", 1, er);
	endtask
	task t_abort;
		for (int s = 3; s < 6; s++) begin
			apb(1'b1, `SDAD_OFS_CMD, {28'h8000_000, s[3:0]});
			apb(1'b1, `SDAD_OFS_CTRL, 32'h1);
			apb(1'b0, `SDAD_OFS_STATUS, 32'h0);
			chk("busy", 3'b001, rd[2:0]);
			apb(1'b1, `SDAD_OFS_CMD, 32'h8000_0000);
			apb(1'b0, `SDAD_OFS_CMD, 32'h0);
			chk("cmd_busy", {28'h8000_000, s[3:0]}, rd);
			presetn <= 1'b0;
			repeat (2) @(posedge pclk);
			presetn <= 1'b1;
		end
	endtask
	initial begin
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		t_single();
		t_seasons();
		t_erase();
		t_reserved();
		t_abort();
		results();
	end
endmodule // sdad_top_test
bind sdad_top sdad_top_asserts chk_u (.pclk, .presetn, .pready, .loc,
	.loc_present, .loc_erase, .rec_valid, .rec_long, .rec_id,
	.rec_value, .rec_ready);
`default_nettype wire
